// ---- design/rfs_pkg.sv ----
// shared constants for the resolver feedback status block
package rfs_pkg;
  // timing, in microseconds, and core clock rate
  localparam int CLK_MHZ       = 100;
  localparam int T_FAST_US     = 250;
  localparam int T_SLOW_US     = 4000;
  localparam int T_IO_US       = 8000;
  localparam int FAST_CYC      = T_FAST_US * CLK_MHZ;
  localparam int FAST_PER_SLOW = T_SLOW_US / T_FAST_US;
  localparam int IO_QUANTA     = T_IO_US / T_SLOW_US;

  // register byte addresses
  localparam logic [7:0] A_IDENT    = 8'h00;
  localparam logic [7:0] A_SW_MAIN  = 8'h04;
  localparam logic [7:0] A_SW_MINOR = 8'h08;
  localparam logic [7:0] A_SPEED    = 8'h0C;
  localparam logic [7:0] A_TURNS    = 8'h10;
  localparam logic [7:0] A_FRAC     = 8'h14;
  localparam logic [7:0] A_POS32    = 8'h18;
  localparam logic [7:0] A_ERR      = 8'h1C;
  localparam logic [7:0] A_CTRL     = 8'h20;
  localparam logic [7:0] A_DETECT   = 8'h24;
  localparam logic [7:0] A_SLOWMODS = 8'h28;
  localparam logic [7:0] A_CMD      = 8'h2C;
  localparam logic [7:0] A_SAVED    = 8'h30;
  localparam logic [7:0] A_IRQ_STAT = 8'h34;
  localparam logic [7:0] A_IRQ_MASK = 8'h38;

  // field positions
  localparam int CTRL_SEL_BIT  = 0;
  localparam int CTRL_RES_LSB  = 1;
  localparam int DET_WIRE_BIT  = 0;
  localparam int CMD_SAVE_BIT  = 0;
  localparam int CMD_RESET_BIT = 1;
  localparam int MODS_IO_LSB   = 4;

  // interrupt event bits
  localparam int EV_ERROR    = 0;
  localparam int EV_MISMATCH = 1;
  localparam int EV_MISSING  = 2;
  localparam int EV_REFRESH  = 3;
  localparam int EV_W        = 4;

  // error status codes
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_EXC_SHORT = 8'h01;
  localparam logic [7:0] ERR_WIRE     = 8'h02;
  localparam logic [7:0] ERR_HOT      = 8'h4A;

  // resolution codes and speed range in 0.1 rpm
  localparam logic [1:0]  RES_10BIT  = 2'h0;
  localparam logic [1:0]  RES_12BIT  = 2'h1;
  localparam logic [15:0] MASK_10BIT = 16'hFFF0;
  localparam logic [15:0] MASK_12BIT = 16'hFFFC;
  localparam logic [15:0] MASK_FULL  = 16'hFFFF;
  localparam logic signed [31:0] SPEED_MAX = 32'sh00061A80;

  // identity: value is arbitrary
  localparam logic [15:0] IDENT_CODE = 16'h0123;
  localparam logic [15:0] IDENT_NONE = 16'h0000;

  typedef enum logic [1:0] {
    RFS_ST_CAPTURE = 2'b00,
    RFS_ST_COMPARE = 2'b01,
    RFS_ST_RUN     = 2'b10
  } rfs_state_t;
endpackage

// ---- design/rfs_refresh_timer.sv ----
// refresh tick generator: fast, position-controller and combined slow ticks
`timescale 1ns/10ps
module rfs_refresh_timer #(
  parameter int FAST_CYC = rfs_pkg::FAST_CYC
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  // slow module population besides this one
  input  wire logic [3:0] extra_4ms_i,
  input  wire logic [3:0] io_8ms_i,
  // ticks
  output logic            fast_tick_o,
  output logic            mid_tick_o,
  output logic            slow_tick_o
);
  logic [31:0] fast_cnt;
  logic [4:0]  mid_cnt;
  logic [7:0]  quanta_cnt;
  logic [7:0]  quanta;

  // this module's own 4ms plus every other slow module
  assign quanta = 8'h01 + {4'h0, extra_4ms_i} +
                  8'(int'(io_8ms_i) * rfs_pkg::IO_QUANTA);

  assign fast_tick_o = (fast_cnt == 32'(FAST_CYC - 1));
  assign mid_tick_o  = fast_tick_o &&
                       (mid_cnt == 5'(rfs_pkg::FAST_PER_SLOW - 1));
  assign slow_tick_o = mid_tick_o && (quanta_cnt >= quanta - 8'h01);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fast_cnt <= 32'h0;
    end else if (fast_tick_o) begin
      fast_cnt <= 32'h0;
    end else begin
      fast_cnt <= fast_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mid_cnt <= 5'h0;
    end else if (mid_tick_o) begin
      mid_cnt <= 5'h0;
    end else if (fast_tick_o) begin
      mid_cnt <= mid_cnt + 5'h1;
    end
  end

  // >= keeps the count sane when the population shrinks mid-period
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quanta_cnt <= 8'h0;
    end else if (slow_tick_o) begin
      quanta_cnt <= 8'h0;
    end else if (mid_tick_o) begin
      quanta_cnt <= quanta_cnt + 8'h1;
    end
  end
endmodule

// ---- design/rfs_top.sv ----
// resolver feedback status block: faults, identity, position and speed
`timescale 1ns/10ps
module rfs_top #(
  parameter int FAST_CYC = rfs_pkg::FAST_CYC
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic [31:0]      reg_rdata_o,
  // angle converter, same clock
  input  wire logic [15:0] angle_i,
  input  wire logic [31:0] speed_raw_i,
  // fault pins from the analogue front end
  input  wire logic        exc_short_i,
  input  wire logic        wire_break_i,
  input  wire logic        overtemp_i,
  // power-up straps and nonvolatile store
  input  wire logic        module_fitted_i,
  input  wire logic        has_software_i,
  input  wire logic [15:0] main_sw_i,
  input  wire logic [15:0] minor_sw_i,
  input  wire logic [15:0] nv_code_i,
  output logic             nv_write_o,
  output logic [15:0]      nv_wdata_o,
  // control-rate feedback
  output logic [31:0]      ctrl_speed_o,
  output logic [31:0]      ctrl_pos_o,
  output logic [31:0]      posctl_pos_o,
  // trips and interrupt
  output logic             slot_error_trip_o,
  output logic             slot_mismatch_trip_o,
  output logic             slot_missing_trip_o,
  output logic             irq_o
);
  localparam int EV_W_IDX = rfs_pkg::EV_W - 1;

  rfs_pkg::rfs_state_t state;

  logic [2:0]  fault_meta;
  logic [2:0]  fault_sync;
  logic        motor_sel;
  logic [1:0]  res_code;
  logic [2:0]  error_detection_level;
  logic [3:0]  extra_4ms;
  logic [3:0]  io_8ms;
  logic [15:0] slot_module_identity;
  logic [15:0] main_software_version;
  logic [15:0] minor_software_version;
  logic [15:0] saved_code;
  logic [7:0]  err_code;
  logic [7:0]  next_err_code;
  logic        slot_mismatch_trip;
  logic        slot_missing_trip;
  logic [15:0] angle_prev;
  logic [15:0] live_turns;
  logic [31:0] measured_speed;
  logic [15:0] turn_counter;
  logic [15:0] fractional_angle;
  logic [EV_W_IDX:0] irq_stat;
  logic [EV_W_IDX:0] irq_mask;
  logic [EV_W_IDX:0] irq_set;
  logic        fast_tick;
  logic        mid_tick;
  logic        slow_tick;
  logic        sample;
  logic        save_cmd;
  logic        reset_cmd;
  logic [15:0] frac_now;
  logic [15:0] next_turns;
  logic [31:0] speed_lim;

  function automatic logic [15:0] res_mask(input logic [1:0] code);
    if (code == rfs_pkg::RES_10BIT) begin
      res_mask = rfs_pkg::MASK_10BIT;
    end else if (code == rfs_pkg::RES_12BIT) begin
      res_mask = rfs_pkg::MASK_12BIT;
    end else begin
      res_mask = rfs_pkg::MASK_FULL;
    end
  endfunction

  function automatic logic [31:0] clamp_speed(input logic [31:0] raw);
    if ($signed(raw) > rfs_pkg::SPEED_MAX) begin
      clamp_speed = rfs_pkg::SPEED_MAX;
    end else if ($signed(raw) < -rfs_pkg::SPEED_MAX) begin
      clamp_speed = -rfs_pkg::SPEED_MAX;
    end else begin
      clamp_speed = raw;
    end
  endfunction

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = reg_write_i && (reg_addr_i == a);
  endfunction

  rfs_refresh_timer #(
    .FAST_CYC(FAST_CYC)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .extra_4ms_i(extra_4ms),
    .io_8ms_i   (io_8ms),
    .fast_tick_o(fast_tick),
    .mid_tick_o (mid_tick),
    .slow_tick_o(slow_tick)
  );

  // fault pins come from another domain
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_meta <= 3'h0;
      fault_sync <= 3'h0;
    end else begin
      fault_meta <= {overtemp_i, wire_break_i, exc_short_i};
      fault_sync <= fault_meta;
    end
  end

  // writable settings
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      motor_sel             <= 1'b0;
      res_code              <= 2'h0;
      error_detection_level <= 3'h0;
      extra_4ms             <= 4'h0;
      io_8ms                <= 4'h0;
      irq_mask              <= '0;
    end else begin
      if (wr_hit(rfs_pkg::A_CTRL)) begin
        motor_sel <= reg_wdata_i[rfs_pkg::CTRL_SEL_BIT];
        res_code  <= reg_wdata_i[rfs_pkg::CTRL_RES_LSB +: 2];
      end
      if (wr_hit(rfs_pkg::A_DETECT)) begin
        error_detection_level <= reg_wdata_i[2:0];
      end
      if (wr_hit(rfs_pkg::A_SLOWMODS)) begin
        extra_4ms <= reg_wdata_i[3:0];
        io_8ms    <= reg_wdata_i[rfs_pkg::MODS_IO_LSB +: 4];
      end
      if (wr_hit(rfs_pkg::A_IRQ_MASK)) begin
        irq_mask <= reg_wdata_i[EV_W_IDX:0];
      end
    end
  end

  assign save_cmd  = wr_hit(rfs_pkg::A_CMD) &&
                     reg_wdata_i[rfs_pkg::CMD_SAVE_BIT];
  assign reset_cmd = wr_hit(rfs_pkg::A_CMD) &&
                     reg_wdata_i[rfs_pkg::CMD_RESET_BIT];

  // power-up: capture straps once, then compare against the saved code
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state                  <= rfs_pkg::RFS_ST_CAPTURE;
      slot_module_identity   <= rfs_pkg::IDENT_NONE;
      main_software_version  <= 16'h0;
      minor_software_version <= 16'h0;
      saved_code             <= 16'h0;
    end else begin
      unique case (state)
        rfs_pkg::RFS_ST_CAPTURE: begin
          slot_module_identity <= module_fitted_i ?
            rfs_pkg::IDENT_CODE : rfs_pkg::IDENT_NONE;
          main_software_version <= (module_fitted_i && has_software_i) ?
            main_sw_i : 16'h0;
          minor_software_version <= (module_fitted_i && has_software_i) ?
            minor_sw_i : 16'h0;
          saved_code <= nv_code_i;
          state      <= rfs_pkg::RFS_ST_COMPARE;
        end
        rfs_pkg::RFS_ST_COMPARE: begin
          state <= rfs_pkg::RFS_ST_RUN;
        end
        rfs_pkg::RFS_ST_RUN: begin
          // identity never rewritten while running
          state <= rfs_pkg::RFS_ST_RUN;
        end
        default: begin
          state <= rfs_pkg::RFS_ST_CAPTURE;
        end
      endcase
    end
  end

  // saved code of zero means nothing was ever saved: no trip
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_mismatch_trip <= 1'b0;
      slot_missing_trip  <= 1'b0;
    end else if (state == rfs_pkg::RFS_ST_COMPARE) begin
      slot_missing_trip <= (saved_code != rfs_pkg::IDENT_NONE) &&
        (slot_module_identity == rfs_pkg::IDENT_NONE);
      slot_mismatch_trip <= (saved_code != rfs_pkg::IDENT_NONE) &&
        (slot_module_identity != rfs_pkg::IDENT_NONE) &&
        (slot_module_identity != saved_code);
    end else if (reset_cmd) begin
      slot_mismatch_trip <= 1'b0;
      slot_missing_trip  <= 1'b0;
    end
  end

  // defaults stay volatile until software asks for a save
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nv_write_o <= 1'b0;
      nv_wdata_o <= 16'h0;
    end else begin
      nv_write_o <= save_cmd && (state == rfs_pkg::RFS_ST_RUN);
      if (save_cmd) begin
        nv_wdata_o <= slot_module_identity;
      end
    end
  end

  // fault code: heat first, then short, then wire break if enabled
  always_comb begin
    next_err_code = err_code;
    if (reset_cmd) begin
      next_err_code = rfs_pkg::ERR_NONE;
    end
    if (fault_sync[2]) begin
      next_err_code = rfs_pkg::ERR_HOT;
    end else if (fault_sync[0]) begin
      next_err_code = rfs_pkg::ERR_EXC_SHORT;
    end else if (fault_sync[1] &&
                 error_detection_level[rfs_pkg::DET_WIRE_BIT]) begin
      next_err_code = rfs_pkg::ERR_WIRE;
    end
  end

  // a fault present during the reset command wins over the clear
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err_code <= rfs_pkg::ERR_NONE;
    end else begin
      err_code <= next_err_code;
    end
  end

  // sampling rate: fast when driving the motor, else only per refresh
  assign sample   = motor_sel ? fast_tick : slow_tick;
  assign frac_now = angle_i & res_mask(res_code);

  // wrap detected from the top two bits; fails above the speed limit
  always_comb begin
    next_turns = live_turns;
    if (angle_prev[15:14] == 2'b11 && angle_i[15:14] == 2'b00) begin
      next_turns = live_turns + 16'h1;
    end else if (angle_prev[15:14] == 2'b00 &&
                 angle_i[15:14] == 2'b11) begin
      next_turns = live_turns - 16'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      angle_prev <= 16'h0;
      live_turns <= 16'h0;
    end else if (sample) begin
      angle_prev <= angle_i;
      live_turns <= next_turns;
    end
  end

  assign speed_lim = clamp_speed(speed_raw_i);

  // control feedback, taken at the sampling rate
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_speed_o <= 32'h0;
      ctrl_pos_o   <= 32'h0;
    end else if (sample) begin
      ctrl_speed_o <= motor_sel ? speed_lim : 32'h0;
      ctrl_pos_o   <= {next_turns, frac_now};
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      posctl_pos_o <= 32'h0;
    end else if (motor_sel ? mid_tick : slow_tick) begin
      posctl_pos_o <= {next_turns, frac_now};
    end
  end

  // parameter-rate values, turns and fraction in one step
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      measured_speed   <= 32'h0;
      turn_counter     <= 16'h0;
      fractional_angle <= 16'h0;
    end else if (slow_tick) begin
      measured_speed   <= motor_sel ? speed_lim : 32'h0;
      turn_counter     <= next_turns;
      fractional_angle <= frac_now;
    end else if (!motor_sel) begin
      measured_speed <= 32'h0;
    end
  end

  // sticky events, write one to clear, set wins
  assign irq_set[rfs_pkg::EV_ERROR]    = (next_err_code != rfs_pkg::ERR_NONE)
                                         && (next_err_code != err_code);
  assign irq_set[rfs_pkg::EV_MISMATCH] = (state == rfs_pkg::RFS_ST_COMPARE)
    && (saved_code != rfs_pkg::IDENT_NONE)
    && (slot_module_identity != rfs_pkg::IDENT_NONE)
    && (slot_module_identity != saved_code);
  assign irq_set[rfs_pkg::EV_MISSING]  = (state == rfs_pkg::RFS_ST_COMPARE)
    && (saved_code != rfs_pkg::IDENT_NONE)
    && (slot_module_identity == rfs_pkg::IDENT_NONE);
  assign irq_set[rfs_pkg::EV_REFRESH]  = slow_tick;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat <= '0;
    end else if (wr_hit(rfs_pkg::A_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~reg_wdata_i[EV_W_IDX:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  assign irq_o                = |(irq_stat & irq_mask);
  assign slot_error_trip_o    = (err_code != rfs_pkg::ERR_NONE);
  assign slot_mismatch_trip_o = slot_mismatch_trip;
  assign slot_missing_trip_o  = slot_missing_trip;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0;
    end else if (!reg_read_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      unique case (reg_addr_i)
        rfs_pkg::A_IDENT:    reg_rdata_o <= {16'h0, slot_module_identity};
        rfs_pkg::A_SW_MAIN:  reg_rdata_o <= {16'h0, main_software_version};
        rfs_pkg::A_SW_MINOR: reg_rdata_o <= {16'h0, minor_software_version};
        rfs_pkg::A_SPEED:    reg_rdata_o <= measured_speed;
        rfs_pkg::A_TURNS:    reg_rdata_o <= {16'h0, turn_counter};
        rfs_pkg::A_FRAC:     reg_rdata_o <= {16'h0, fractional_angle};
        rfs_pkg::A_POS32:
          reg_rdata_o <= {turn_counter, fractional_angle};
        rfs_pkg::A_ERR:      reg_rdata_o <= {24'h0, err_code};
        rfs_pkg::A_CTRL:
          reg_rdata_o <= {29'h0, res_code, motor_sel};
        rfs_pkg::A_DETECT:   reg_rdata_o <= {29'h0, error_detection_level};
        rfs_pkg::A_SLOWMODS: reg_rdata_o <= {24'h0, io_8ms, extra_4ms};
        rfs_pkg::A_SAVED:    reg_rdata_o <= {16'h0, saved_code};
        rfs_pkg::A_IRQ_STAT: reg_rdata_o <= {28'h0, irq_stat};
        rfs_pkg::A_IRQ_MASK: reg_rdata_o <= {28'h0, irq_mask};
        default:             reg_rdata_o <= 32'h0;
      endcase
    end
  end
endmodule

// ---- tb/rfs_top_assertions.sv ----
// concurrent checks on the resolver feedback status block ports
`timescale 1ns/10ps
module rfs_checker #(
  parameter int FAST_CYC = rfs_pkg::FAST_CYC
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  input  wire logic [31:0] reg_rdata_o,
  // fault pins
  input  wire logic        exc_short_i,
  input  wire logic        overtemp_i,
  // outputs watched
  input  wire logic        nv_write_o,
  input  wire logic [31:0] ctrl_pos_o,
  input  wire logic [31:0] posctl_pos_o,
  input  wire logic        slot_error_trip_o,
  input  wire logic        slot_mismatch_trip_o,
  input  wire logic        slot_missing_trip_o,
  input  wire logic        irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // cycles since the position-controller word last moved, saturating
  logic [31:0] pc_cnt;
  logic [31:0] posctl_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_cnt   <= 32'hFFFFFFFF;
      posctl_q <= 32'h0;
    end else begin
      posctl_q <= posctl_pos_o;
      if (posctl_pos_o != posctl_q) begin
        pc_cnt <= 32'h0;
      end else if (pc_cnt != 32'hFFFFFFFF) begin
        pc_cnt <= pc_cnt + 32'h1;
      end
    end
  end

  rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside answer cycle");
  hot_trip_a: assert property (overtemp_i [*4] |=> slot_error_trip_o)
    else $error("overheat did not raise slot error trip");
  short_trip_a: assert property ($rose(exc_short_i) ##1 exc_short_i [*3]
    |=> slot_error_trip_o)
    else $error("excitation short did not raise slot error trip");
  mask_quiet_a: assert property (reg_write_i
    && reg_addr_i == rfs_pkg::A_IRQ_MASK && reg_wdata_i[3:0] == 4'h0
    |=> !irq_o) else $error("interrupt high with all events masked");
  nv_pulse_a: assert property (nv_write_o |=> !nv_write_o)
    else $error("store pulse longer than one cycle");
  nv_save_a: assert property (reg_write_i && reg_addr_i == rfs_pkg::A_CMD
    && reg_wdata_i[0] |-> ##[1:2] nv_write_o)
    else $error("save command did not store");
  ctrl_pace_a: assert property ($changed(ctrl_pos_o)
    |=> $stable(ctrl_pos_o) [*8])
    else $error("control position refreshed faster than fast rate");
  posctl_pace_a: assert property (posctl_pos_o != posctl_q
    |-> pc_cnt >= 16 * FAST_CYC - 1)
    else $error("position controller word refreshed too early");
  powerup_trip_a: assert property ($rose(slot_mismatch_trip_o
    || slot_missing_trip_o) |-> !$past(reset_n_i, 2)
    || !$past(reset_n_i, 3) || !$past(reset_n_i, 4))
    else $error("slot trip raised outside power-up compare");
endmodule

bind rfs_top rfs_checker #(.FAST_CYC(FAST_CYC)) rfs_checker_inst (
  .core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
  .reg_read_i, .reg_rdata_o, .exc_short_i, .overtemp_i, .nv_write_o,
  .ctrl_pos_o, .posctl_pos_o, .slot_error_trip_o, .slot_mismatch_trip_o,
  .slot_missing_trip_o, .irq_o
);

// ---- tb/rfs_resolver_model.sv ----
// resolver and angle converter model driven by a signed rate per clock
`timescale 1ns/10ps
module rfs_resolver_model (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // commanded motion per clock
  input  wire logic [31:0] rate_i,
  // converter outputs and reference position
  output logic [15:0]      angle_o,
  output logic [31:0]      speed_o,
  output logic [31:0]      pos_o
);
  // whole turns kept above the angle, so the bench has a reference
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pos_o <= 32'h0;
    end else begin
      pos_o <= pos_o + rate_i;
    end
  end
  assign angle_o = pos_o[15:0];
  // speed in the same signed units as the rate
  assign speed_o = rate_i;
endmodule

// ---- tb/tb_rfs_top.sv ----
// self-checking bench for the resolver feedback status block
`timescale 1ns/10ps
module tb_rfs_top;
  localparam int FC = 10;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i = 1'b0;
  logic [31:0] reg_rdata_o, speed_raw_i, pos_ref, n;
  logic [31:0] rate = 32'h0;
  logic [15:0] angle_i, nv_wdata_o;
  logic [2:0]  faults = 3'h0;
  logic        fitted = 1'b1;
  logic        has_sw = 1'b1;
  logic [15:0] nv_code = 16'h0000;
  logic        nv_write_o, trip_err, trip_mis, trip_miss, irq_o;
  logic [31:0] ctrl_speed_o, ctrl_pos_o, posctl_pos_o;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          nv_cnt = 0;

  always #5 core_clk_i = ~core_clk_i;

  rfs_top #(.FAST_CYC(FC)) rfs_top_inst (
    .core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
    .reg_read_i, .reg_rdata_o, .angle_i, .speed_raw_i,
    .exc_short_i(faults[0]), .wire_break_i(faults[1]),
    .overtemp_i(faults[2]), .module_fitted_i(fitted),
    .has_software_i(has_sw), .main_sw_i(16'h0304), .minor_sw_i(16'h0012),
    .nv_code_i(nv_code), .nv_write_o, .nv_wdata_o, .ctrl_speed_o,
    .ctrl_pos_o, .posctl_pos_o, .slot_error_trip_o(trip_err),
    .slot_mismatch_trip_o(trip_mis), .slot_missing_trip_o(trip_miss), .irq_o
  );
  rfs_resolver_model rfs_resolver_model_inst (
    .core_clk_i, .reset_n_i, .rate_i(rate), .angle_o(angle_i),
    .speed_o(speed_raw_i), .pos_o(pos_ref)
  );

  task close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard well beyond the planned run
  always @(posedge core_clk_i) begin
    cyc++;
    if (nv_write_o === 1'b1) nv_cnt++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask

  task do_reset(input logic f, input logic s, input logic [15:0] nv);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    fitted    <= f;
    has_sw    <= s;
    nv_code   <= nv;
    repeat (16) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask

  function automatic logic [31:0] pick(input bit w);
    return w ? ctrl_pos_o : posctl_pos_o;
  endfunction

  // cycles between two successive changes of the chosen position word
  task gap(input bit w);
    logic [31:0] v;
    int c;
    c = 0;
    v = pick(w);
    while (pick(w) === v && c < 2000) begin
      @(posedge core_clk_i);
      c++;
    end
    v = pick(w);
    n = 0;
    while (pick(w) === v && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
  endtask

  task t_ident;
    rd(rfs_pkg::A_IDENT, {16'h0, rfs_pkg::IDENT_CODE});
    rd(rfs_pkg::A_SW_MINOR, 32'h0012);
    rd(rfs_pkg::A_SW_MAIN, 32'h0304);
    wr(rfs_pkg::A_IDENT, 32'h5A5A);
    rd(rfs_pkg::A_IDENT, {16'h0, rfs_pkg::IDENT_CODE});
    rd(8'hFC, 32'h0);
    chk(nv_cnt, 32'h0);
    wr(rfs_pkg::A_CMD, 32'h1);
    repeat (3) @(posedge core_clk_i);
    chk(nv_cnt, 32'h1);
    chk({16'h0, nv_wdata_o}, {16'h0, rfs_pkg::IDENT_CODE});
  endtask

  task t_powerup;
    do_reset(1'b1, 1'b1, 16'h0077);
    chk({trip_mis, trip_miss}, 32'h2);
    rd(rfs_pkg::A_SAVED, 32'h0077);
    rd(rfs_pkg::A_IRQ_STAT, 32'h2);
    do_reset(1'b0, 1'b0, rfs_pkg::IDENT_CODE);
    chk({trip_mis, trip_miss}, 32'h1);
    rd(rfs_pkg::A_IDENT, 32'h0);
    rd(rfs_pkg::A_SW_MAIN, 32'h0);
    rd(rfs_pkg::A_SW_MINOR, 32'h0);
    do_reset(1'b1, 1'b0, rfs_pkg::IDENT_CODE);
    chk({trip_mis, trip_miss}, 32'h0);
    rd(rfs_pkg::A_SW_MAIN, 32'h0);
    rd(rfs_pkg::A_SW_MINOR, 32'h0);
  endtask

  task t_faults;
    logic [2:0] dv [6] = '{3'h0, 3'h6, 3'h1, 3'h1, 3'h7, 3'h1};
    logic [2:0] pv [6] = '{3'h2, 3'h2, 3'h2, 3'h1, 3'h4, 3'h5};
    logic [7:0] cv [6] = '{8'h00, 8'h00, 8'h02, 8'h01, 8'h4A, 8'h4A};
    wr(rfs_pkg::A_IRQ_MASK, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(rfs_pkg::A_DETECT, {29'h0, dv[i]});
      @(posedge core_clk_i) faults <= pv[i];
      repeat (6) @(posedge core_clk_i);
      rd(rfs_pkg::A_ERR, {24'h0, cv[i]});
      chk(trip_err, cv[i] != 8'h00);
      chk(irq_o, cv[i] != 8'h00);
      wr(rfs_pkg::A_IRQ_MASK, 32'h0);
      chk(irq_o, 1'b0);
      wr(rfs_pkg::A_IRQ_MASK, 32'h1);
      @(posedge core_clk_i) faults <= 3'h0;
      repeat (4) @(posedge core_clk_i);
      wr(rfs_pkg::A_CMD, 32'h2);
      wr(rfs_pkg::A_IRQ_STAT, 32'hF);
      rd(rfs_pkg::A_ERR, 32'h0);
      chk(irq_o, 1'b0);
    end
  endtask

  task t_motion;
    wr(rfs_pkg::A_CTRL, 32'h5);
    @(posedge core_clk_i) rate <= 32'hFFFFFE7D;
    repeat (300) @(posedge core_clk_i);
    rd(rfs_pkg::A_SPEED, 32'hFFFFFE7D);
    chk(ctrl_speed_o, 32'hFFFFFE7D);
    repeat (1700) @(posedge core_clk_i);
    rate <= 32'h0;
    repeat (200) @(posedge core_clk_i);
    rd(rfs_pkg::A_POS32, pos_ref);
    rd(rfs_pkg::A_TURNS, {16'h0, pos_ref[31:16]});
    rd(rfs_pkg::A_FRAC, {16'h0, pos_ref[15:0]});
    chk(ctrl_pos_o, pos_ref);
    chk(posctl_pos_o, pos_ref);
    @(posedge core_clk_i) rate <= 32'h00000201;
    repeat (1000) @(posedge core_clk_i);
    rate <= 32'h0;
    wr(rfs_pkg::A_CTRL, 32'h1);
    repeat (200) @(posedge core_clk_i);
    rd(rfs_pkg::A_FRAC, {16'h0, pos_ref[15:0] & 16'hFFF0});
    rd(rfs_pkg::A_TURNS, {16'h0, pos_ref[31:16]});
    wr(rfs_pkg::A_CTRL, 32'h3);
    repeat (200) @(posedge core_clk_i);
    rd(rfs_pkg::A_FRAC, {16'h0, pos_ref[15:0] & 16'hFFFC});
  endtask

  task t_unsel;
    wr(rfs_pkg::A_CTRL, 32'h4);
    @(posedge core_clk_i) rate <= 32'h00000010;
    gap(1'b0);
    chk(n, 16 * FC);
    rd(rfs_pkg::A_SPEED, 32'h0);
    chk(ctrl_speed_o, 32'h0);
    wr(rfs_pkg::A_SLOWMODS, 32'h10);
    gap(1'b0);
    gap(1'b0);
    chk(n, 48 * FC);
    gap(1'b1);
    chk(n, 48 * FC);
    wr(rfs_pkg::A_CTRL, 32'h5);
    gap(1'b1);
    chk(n, FC);
    gap(1'b0);
    gap(1'b0);
    chk(n, 16 * FC);
    rate <= 32'h0;
    repeat (600) @(posedge core_clk_i);
    rd(rfs_pkg::A_POS32, pos_ref);
    // far beyond the speed range: control speed must saturate
    @(posedge core_clk_i) rate <= 32'hFFF00000;
    repeat (200) @(posedge core_clk_i);
    chk(ctrl_speed_o, -rfs_pkg::SPEED_MAX);
  endtask

  initial begin
    do_reset(1'b1, 1'b1, 16'h0000);
    t_ident;
    t_powerup;
    t_faults;
    t_motion;
    t_unsel;
    close_out;
  end
endmodule
